// File: rtl/aam_capture.sv
`timescale 1ns/1ps
// Contract
// - augmented mode exists only on mux parts; enabled by config bit set to 1.
// - reset returns device to plain multiplexed mode, augmented mode off.
// - entering augmented mode loads the upper-address latch with zeros.
// - both address halves come from the shared 16-bit bus.
// - output-enable low latches upper half, high latches lower half.
// - single lower phase combines with the most recent upper address.
// - every read starts sensing when the lower address is latched, except a second restart during a pending sense.
// - in augmented mode, wait indicator driven exactly while the data bus is driven.
// - async mode wait shows valid; sync mode valid after latency lapses.
// - two pulses: first edge upper with oe low, second lower with oe high.
// - only one restart before pending sense; the next read must complete.
// - async read access time counted from address-valid rising edge.
// - synchronous cycles latch phases on rising link clock edges.
// - synchronous writes complete on write-enable rising edge only.
module aam_capture
   import aam_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic mux_configured,
   input wire logic chip_en_n,
   input wire logic output_en_n,
   input wire logic write_en_n,
   input wire logic address_valid_n,
   input wire logic link_clk,
   input wire logic [15:0] dq_in,
   input wire logic cfg_write,
   input wire logic [15:0] cfg_data,
   input wire logic [15:0] array_rdata,
   output logic [15:0] dq_out,
   output logic dq_oe,
   output logic wait_out,
   output logic wait_oe,
   output logic sense_start,
   output logic write_strobe,
   output logic [`AAM_UPPER_W+`AAM_LOWER_W-1:0] array_addr,
   output logic [15:0] array_wdata,
   output logic aug_mode,
   output logic restart_refused
);
   localparam logic [`AAM_CNT_W-1:0] ACCESS_CYC = `AAM_CNT_W'(`AAM_ACCESS_CYC);
   localparam logic [`AAM_CNT_W-1:0] LATENCY_CYC = `AAM_CNT_W'(`AAM_LATENCY_CYC);

   aam_state_t s_reg;
   aam_state_t s_next;
   aam_pins_t p_reg;
   aam_pins_t p_meta;
   logic refused_reg;
   logic refused_next;

   // two-flop synchroniser on all host pins; first stage feeds only the second
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         p_meta <= '{chip_en_n: 1'b1, output_en_n: 1'b1, write_en_n: 1'b1,
                     address_valid_n: 1'b1, link_clk: 1'b0, data: 16'h0000};
         p_reg <= '{chip_en_n: 1'b1, output_en_n: 1'b1, write_en_n: 1'b1,
                    address_valid_n: 1'b1, link_clk: 1'b0, data: 16'h0000};
      end
      else
      begin
         p_meta <= '{chip_en_n: chip_en_n, output_en_n: output_en_n,
                     write_en_n: write_en_n, address_valid_n: address_valid_n,
                     link_clk: link_clk, data: dq_in};
         p_reg <= p_meta;
      end
   end

   function automatic logic rise(input logic prev, input logic now);
      rise = !prev && now;
   endfunction

   // next-state logic for the whole capture front end
   always_comb
   begin
      logic async_mode;
      logic aug;
      logic adv_rise;
      logic clk_rise;
      logic latch_ev;
      logic lower_ev;
      logic oe_active;
      async_mode = 1'b0;
      aug = 1'b0;
      adv_rise = 1'b0;
      clk_rise = 1'b0;
      latch_ev = 1'b0;
      lower_ev = 1'b0;
      oe_active = 1'b0;
      s_next = s_reg;
      refused_next = 1'b0;
      s_next.req.sense_start = 1'b0;
      s_next.req.write_strobe = 1'b0;
      s_next.adv_prev = p_reg.address_valid_n;
      s_next.lclk_prev = p_reg.link_clk;
      s_next.we_prev = p_reg.write_en_n;
      s_next.sync_a_0 = 2'h0;
      s_next.sync_a_1 = 2'h0;
      async_mode = s_reg.read_configuration_register[`AAM_RCR_ASYNC_BIT];
      aug = s_reg.read_configuration_register[`AAM_RCR_ENABLE_BIT];
      if (cfg_write)
      begin
         s_next.read_configuration_register = cfg_data;
         s_next.read_configuration_register[`AAM_RCR_ENABLE_BIT] = cfg_data[`AAM_RCR_ENABLE_BIT] && mux_configured;
         if (!aug && s_next.read_configuration_register[`AAM_RCR_ENABLE_BIT])
         begin
            s_next.upper = '0;
         end
      end
      adv_rise = rise(s_reg.adv_prev, p_reg.address_valid_n);
      clk_rise = rise(s_reg.lclk_prev, p_reg.link_clk);
      // sync latches on clock edge; async on address-valid rise
      if (async_mode)
      begin
         latch_ev = adv_rise;
      end
      else
      begin
         latch_ev = clk_rise && !p_reg.address_valid_n;
      end
      latch_ev = latch_ev && !p_reg.chip_en_n && aug;
      if (latch_ev && p_reg.output_en_n)
      begin
         lower_ev = 1'b1;
         s_next.lower = p_reg.data;
      end
      else if (latch_ev)
      begin
         // upper only changes here, on entry to augmented mode, or at reset
         s_next.upper = p_reg.data[`AAM_UPPER_W-1:0];
      end
      // plain multiplexed mode: one address-valid edge latches the lower half
      if (!aug && adv_rise && !p_reg.chip_en_n)
      begin
         lower_ev = 1'b1;
         s_next.lower = p_reg.data;
      end
      s_next.req.addr = {s_next.upper, s_next.lower};
      case (s_reg.phase)
         AAM_IDLE:
         begin
            s_next.restarted = 1'b0;
         end
         AAM_SENSE:
         begin
            if (s_reg.cnt != '0)
            begin
               s_next.cnt = s_reg.cnt - `AAM_CNT_W'(1);
            end
            else
            begin
               s_next.phase = AAM_READY;
               s_next.restarted = 1'b0;
            end
         end
         AAM_READY:
         begin
            if (p_reg.chip_en_n)
            begin
               s_next.phase = AAM_IDLE;
            end
         end
         AAM_WRITE:
         begin
            if (rise(s_reg.we_prev, p_reg.write_en_n))
            begin
               s_next.req.write_strobe = 1'b1;
               s_next.req.wdata = p_reg.data;
               s_next.phase = AAM_IDLE;
            end
         end
         default:
         begin
            s_next.phase = AAM_IDLE;
         end
      endcase
      // sense starts at lower capture, one restart allowed
      if (lower_ev)
      begin
         if (!p_reg.write_en_n)
         begin
            s_next.phase = AAM_WRITE;
         end
         else if (s_reg.phase == AAM_SENSE && s_reg.restarted)
         begin
            refused_next = 1'b1;
         end
         else
         begin
            s_next.restarted = (s_reg.phase == AAM_SENSE);
            s_next.req.sense_start = 1'b1;
            s_next.phase = AAM_SENSE;
            // access from latch edge, sync uses latency count
            s_next.cnt = async_mode ? ACCESS_CYC : LATENCY_CYC;
         end
      end
      else if (s_reg.phase == AAM_IDLE && !p_reg.write_en_n && !p_reg.chip_en_n)
      begin
         s_next.phase = AAM_WRITE;
      end
      oe_active = !p_reg.chip_en_n && !p_reg.output_en_n && p_reg.write_en_n;
      s_next.dq_oe = oe_active;
      s_next.dq_out = array_rdata;
      // wait follows data enable in augmented mode
      s_next.wait_oe = oe_active && aug;
      s_next.wait_out = async_mode || (s_next.phase == AAM_READY);
   end

   // single state register; reset to plain mux mode
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_reg <= '0;
         s_reg.phase <= AAM_IDLE;
         s_reg.read_configuration_register <= `AAM_RCR_RESET;
         s_reg.adv_prev <= 1'b1;
         s_reg.we_prev <= 1'b1;
         refused_reg <= 1'b0;
      end
      else
      begin
         s_reg <= s_next;
         refused_reg <= refused_next;
      end
   end

   // outputs straight from flops
   assign dq_out = s_reg.dq_out;
   assign dq_oe = s_reg.dq_oe;
   assign wait_out = s_reg.wait_out;
   assign wait_oe = s_reg.wait_oe;
   assign sense_start = s_reg.req.sense_start;
   assign write_strobe = s_reg.req.write_strobe;
   assign array_addr = s_reg.req.addr;
   assign array_wdata = s_reg.req.wdata;
   assign aug_mode = s_reg.read_configuration_register[`AAM_RCR_ENABLE_BIT];
   assign restart_refused = refused_reg;
endmodule // aam_capture

// File: rtl/aam_defines.svh
`ifndef AAM_DEFINES_SVH
`define AAM_DEFINES_SVH
// address widths
`define AAM_UPPER_W 10
`define AAM_LOWER_W 16
// read configuration register field positions
`define AAM_RCR_ASYNC_BIT 15
`define AAM_RCR_ENABLE_BIT 4
// read configuration reset value: asynchronous, augmented mode off
`define AAM_RCR_RESET 16'h8000
// read access from address-valid rising edge, in ns
`define AAM_ACCESS_NS 106
`define AAM_CLK_NS 5
`define AAM_ACCESS_CYC ((`AAM_ACCESS_NS) / (`AAM_CLK_NS))
// synchronous latency count default
`define AAM_LATENCY_CYC 4
`define AAM_CNT_W 8
`endif

// File: rtl/aam_pkg.sv
package aam_pkg;
`include "aam_defines.svh"
   typedef enum logic [3:0]
   {
      AAM_IDLE = 4'h1,
      AAM_SENSE = 4'h2,
      AAM_READY = 4'h4,
      AAM_WRITE = 4'h8
   } aam_phase_t;
   // host-side pins after synchronisation
   typedef struct packed
   {
      logic chip_en_n;
      logic output_en_n;
      logic write_en_n;
      logic address_valid_n;
      logic link_clk;
      logic [15:0] data;
   } aam_pins_t;
   // array request toward the core
   typedef struct packed
   {
      logic sense_start;
      logic write_strobe;
      logic [`AAM_UPPER_W+`AAM_LOWER_W-1:0] addr;
      logic [15:0] wdata;
   } aam_req_t;
   typedef struct packed
   {
      aam_phase_t phase;
      logic [15:0] read_configuration_register;
      logic [`AAM_UPPER_W-1:0] upper;
      logic [`AAM_LOWER_W-1:0] lower;
      logic [`AAM_CNT_W-1:0] cnt;
      logic restarted;
      logic adv_prev;
      logic lclk_prev;
      logic we_prev;
      aam_req_t req;
      logic [15:0] dq_out;
      logic dq_oe;
      logic wait_out;
      logic wait_oe;
      logic [1:0] sync_a_0;
      logic [1:0] sync_a_1;
   } aam_state_t;
endpackage

// File: bench/aam_capture_sva.sv
`timescale 1ns/1ps
module aam_chk
   import aam_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic mux_configured,
   input wire logic cfg_write,
   input wire logic dq_oe,
   input wire logic wait_oe,
   input wire logic sense_start,
   input wire logic write_strobe,
   input wire logic aug_mode,
   input wire logic restart_refused
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // pin enables, mode and strobes; each ties an output to its cause, excludes two strobes, or bounds a pulse to one cycle
   a_wait_tracks_dq: assert property ($past(aug_mode) |-> wait_oe == dq_oe)
      else $error("wait enable differs from data enable");
   a_reset_mode_off: assert property ($past(sys_rst) |-> !aug_mode)
      else $error("augmented mode on after reset");
   a_mode_needs_strap: assert property ($rose(aug_mode) |-> $past(mux_configured))
      else $error("augmented mode entered without mux strap");
   a_mode_by_config: assert property ($changed(aug_mode) |-> $past(cfg_write))
      else $error("mode changed without config write");
   a_sense_one_pulse: assert property (sense_start |=> !sense_start)
      else $error("sense start longer than one cycle");
   a_refuse_no_sense: assert property (restart_refused |-> !sense_start)
      else $error("refused restart still sensed");
   a_write_no_sense: assert property (write_strobe |-> !sense_start)
      else $error("write strobe with sense start");
   a_write_one_pulse: assert property (write_strobe |=> !write_strobe)
      else $error("write strobe longer than one cycle");
endmodule // aam_chk
bind aam_capture aam_chk u_chk (.clock, .sys_rst, .mux_configured, .cfg_write, .dq_oe,
   .wait_oe, .sense_start, .write_strobe, .aug_mode, .restart_refused);

// File: bench/aam_host.sv
`timescale 1ns/1ps
module aam_host
   import aam_pkg::*;
(
   input wire logic clock,
   output aam_pins_t pins
);
   // idle bus: all strobes high, link clock still
   initial pins = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'hffff};
   task automatic phase(input logic oe_n, input logic [15:0] a, input logic sync);
      @(negedge clock);
      pins.chip_en_n = 1'b0;
      pins.output_en_n = oe_n;
      pins.data = a;
      pins.address_valid_n = 1'b0;
      repeat (3) @(negedge clock);
      pins.link_clk = sync;
      repeat (3) @(negedge clock);
      pins.link_clk = 1'b0;
      pins.address_valid_n = 1'b1;
      repeat (8) @(negedge clock);
      // released bus shows the inverse, so a stale address never matches
      pins.data = ~a;
   endtask
   task automatic write_end(input logic [15:0] d);
      // one edge after the address phase so the bus changes once per step
      @(negedge clock);
      pins.data = d;
      repeat (3) @(negedge clock);
      pins.write_en_n = 1'b1;
      repeat (6) @(negedge clock);
   endtask
   task automatic set_we(input logic v);
      pins.write_en_n = v;
   endtask
   // data phase: output-enable low hands the bus to the device
   task automatic set_oe(input logic v);
      pins.output_en_n = v;
   endtask
endmodule // aam_host

// File: bench/aam_capture_tb.sv
`timescale 1ns/1ps
`include "aam_defines.svh"
module aam_capture_tb
   import aam_pkg::*;
;
   logic clock, sys_rst, mux_configured, cfg_write, dq_oe, wait_out, wait_oe;
   logic sense_start, write_strobe, aug_mode, restart_refused;
   logic [15:0] cfg_data, array_rdata, dq_out, array_wdata, seen_wdata;
   logic [`AAM_UPPER_W+`AAM_LOWER_W-1:0] array_addr, seen_addr;
   aam_pins_t pins;
   int miscompares, total_checks, n_sense, n_wr, n_ref, cycles;
   logic seen_wait;
   aam_host host (.clock(clock), .pins(pins));
   aam_capture dut (.clock(clock), .sys_rst(sys_rst), .mux_configured(mux_configured),
      .chip_en_n(pins.chip_en_n), .output_en_n(pins.output_en_n),
      .write_en_n(pins.write_en_n), .address_valid_n(pins.address_valid_n),
      .link_clk(pins.link_clk), .dq_in(pins.data), .cfg_write(cfg_write),
      .cfg_data(cfg_data), .array_rdata(array_rdata), .dq_out(dq_out), .dq_oe(dq_oe),
      .wait_out(wait_out), .wait_oe(wait_oe), .sense_start(sense_start),
      .write_strobe(write_strobe), .array_addr(array_addr), .array_wdata(array_wdata),
      .aug_mode(aug_mode), .restart_refused(restart_refused));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // strobe monitor and hang guard; the whole run should end well inside the ceiling
   always @(posedge clock)
   begin
      cycles++;
      if (sense_start === 1'b1)
      begin
         n_sense++;
         seen_addr = array_addr;
         seen_wait = wait_out;
      end
      if (restart_refused === 1'b1)
      begin
         n_ref++;
      end
      if (write_strobe === 1'b1)
      begin
         n_wr++;
         seen_wdata = array_wdata;
         seen_addr = array_addr;
      end
      if (cycles == 4000)
      begin
         miscompares++;
         summarize();
      end
   end
   task automatic cfg(input logic [15:0] v);
      @(negedge clock);
      cfg_data = v;
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_write = 1'b0;
      repeat (3) @(negedge clock);
   endtask
   task automatic upper(input logic [9:0] up, input logic sync);
      int n;
      n = n_sense;
      host.phase(1'b0, {6'h00, up}, sync);
      check("upper no sense", n, n_sense);
   endtask
   task automatic lower_read(input logic [15:0] lo, input logic sync, input logic [25:0] exp);
      int n;
      n = n_sense;
      host.phase(1'b1, lo, sync);
      check("sense count", n + 1, n_sense);
      check("read address", exp, seen_addr);
      check("wait at sense start", !sync, seen_wait);
      check("wait after latency", 1'b1, wait_out);
   endtask
   task automatic t_strap();
      check("mode after reset", 1'b0, aug_mode);
      mux_configured = 1'b0;
      cfg(16'h8010);
      check("mode without strap", 1'b0, aug_mode);
      lower_read(16'h0abc, 1'b0, {10'h000, 16'h0abc});
      mux_configured = 1'b1;
      cfg(16'h8010);
      check("mode with strap", 1'b1, aug_mode);
      lower_read(16'h1234, 1'b0, {10'h000, 16'h1234});
   endtask
   task automatic t_two_phase_keep();
      upper(10'h2a5, 1'b0);
      lower_read(16'hbeef, 1'b0, {10'h2a5, 16'hbeef});
      lower_read(16'h0001, 1'b0, {10'h2a5, 16'h0001});
      host.set_oe(1'b0);
      repeat (4) @(negedge clock);
      check("data driven", 1'b1, dq_oe);
      check("wait driven", 1'b1, wait_oe);
      check("read data", 16'h5a5a, dq_out);
      check("async wait valid", 1'b1, wait_out);
      host.set_oe(1'b1);
      repeat (4) @(negedge clock);
      check("data released", 1'b0, dq_oe);
      check("wait released", 1'b0, wait_oe);
   endtask
   task automatic t_sync_write();
      int n;
      cfg(16'h0010);
      upper(10'h011, 1'b1);
      lower_read(16'h4321, 1'b1, {10'h011, 16'h4321});
      n = n_wr;
      host.set_we(1'b0);
      host.phase(1'b1, 16'h0777, 1'b1);
      host.write_end(16'hc0de);
      check("write count", n + 1, n_wr);
      check("write data", 16'hc0de, seen_wdata);
      check("write address", {10'h011, 16'h0777}, seen_addr);
   endtask
   task automatic t_reset_mid();
      cfg(16'h0000);
      cfg(16'h0010);
      lower_read(16'h0003, 1'b1, {10'h000, 16'h0003});
      @(negedge clock);
      sys_rst = 1'b1;
      repeat (3) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      check("mode after mid reset", 1'b0, aug_mode);
      cfg(16'h8010);
      lower_read(16'h0002, 1'b0, {10'h000, 16'h0002});
   endtask
   // reads 15 cycles apart: one restart inside a sense passes, the second is refused
   task automatic t_restart_refuse();
      int n;
      int r;
      lower_read(16'h0010, 1'b0, {10'h000, 16'h0010});
      n = n_sense;
      r = n_ref;
      host.phase(1'b1, 16'h0020, 1'b0);
      check("second restart no sense", n, n_sense);
      check("second restart refused", r + 1, n_ref);
      lower_read(16'h0030, 1'b0, {10'h000, 16'h0030});
   endtask
   // main sequence: reset held 10 cycles, then the scenarios
   initial
   begin
      sys_rst = 1'b1;
      mux_configured = 1'b1;
      cfg_write = 1'b0;
      cfg_data = 16'h8000;
      array_rdata = 16'h5a5a;
      repeat (10) @(negedge clock);
      sys_rst = 1'b0;
      repeat (3) @(negedge clock);
      t_strap();
      t_two_phase_keep();
      t_sync_write();
      t_reset_mid();
      t_restart_refuse();
      summarize();
   end
endmodule // aam_capture_tb
